// File: inc/utfs_pkg.sv
// Shared constants for the transmit FIFO status flag block
package utfs_pkg;
  // Register byte offsets
  localparam logic [4:0] OFS_FLAG = 5'h00;
  localparam logic [4:0] OFS_CTRL = 5'h04;
  localparam logic [4:0] OFS_ISTS = 5'h08;
  localparam logic [4:0] OFS_IMSK = 5'h0C;
  localparam logic [4:0] OFS_FSZ  = 5'h10;
  // Flag register fields
  localparam int FLG_IDX_HI = 7;
  localparam int FLG_IDX_LO = 6;
  localparam int FLG_EMPTY  = 3;
  localparam int FLG_FULL   = 2;
  localparam int FLG_OVF    = 0;
  // Control register fields
  localparam int CTL_FEAT   = 0;
  localparam int CTL_ISO    = 1;
  // Interrupt event bits
  localparam int IRQ_W      = 3;
  localparam int EV_OVF     = 0;
  localparam int EV_DISC    = 1;
  localparam int EV_SENT    = 2;
  // Widths, reset values and limits
  localparam int SZ_W       = 11;
  localparam logic [SZ_W-1:0] FSZ_RST  = 11'h040;
  localparam logic [1:0]      CTL_RST  = 2'h0;
  localparam logic [1:0]      IDX_MAX  = 2'h3;
  localparam logic [2:0]      SET_MAX  = 3'h3;
  // Bus slave states
  typedef enum logic [1:0] {
    WB_IDLE = 2'b01,
    WB_ACK  = 2'b10
  } utfs_wb_e;
endpackage

// File: hdl/utfs_irq.sv
// Sticky event status with mask and one level interrupt
`timescale 1ns/10ps
module utfs_irq #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Events and software access
  input  wire logic [W-1:0] ev,
  input  wire logic         clr_we,
  input  wire logic         msk_we,
  input  wire logic [W-1:0] wdat,
  // State
  output logic      [W-1:0] status,
  output logic      [W-1:0] mask,
  output logic              irq
);
  logic [W-1:0] sts_r, sts_nxt;  // Sticky bits
  logic [W-1:0] msk_r, msk_nxt;  // Mask, one enables
  logic         irq_r, irq_nxt;  // Level output

  // Next values; a new event beats a clear in the same cycle
  always_comb begin
    sts_nxt = (sts_r & ~(clr_we ? wdat : '0)) | ev;
    msk_nxt = msk_we ? wdat : msk_r;
    irq_nxt = |(sts_nxt & msk_nxt);
  end

  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sts_r <= '0;
      msk_r <= '0;
      irq_r <= 1'b0;
    end else begin
      sts_r <= sts_nxt;
      msk_r <= msk_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign status = sts_r;
  assign mask   = msk_r;
  assign irq    = irq_r;
endmodule

// File: hdl/utfs_set_track.sv
// Data set counting with frame deferred host visibility
`timescale 1ns/10ps
module utfs_set_track (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Mode
  input  wire logic       feat,
  input  wire logic       iso,
  // Events
  input  wire logic       sof,
  input  wire logic       cnt_wr,
  input  wire logic       in_token,
  input  wire logic       tx_done,
  // Status
  output logic      [1:0] idx,
  output logic            avail,
  output logic            ovf,
  output logic            disc
);
  import utfs_pkg::*;
  logic [2:0] cnt_r, cnt_nxt;    // Sets held
  logic [2:0] frs_r, frs_nxt;    // Sets hidden until SOF
  logic [2:0] pnd_r, pnd_nxt;    // Sent sets awaiting SOF
  logic       zlp_r, zlp_nxt;    // Zero length sent this frame
  logic       late_r, late_nxt;  // Oldest set arrived late
  logic [2:0] vis;
  logic       tx_ok;

  // Host sees only sets neither hidden nor already sent
  assign vis   = cnt_r - frs_r - pnd_r;
  assign tx_ok = tx_done && (vis != 3'h0);

  // Next values: SOF step, USB step, firmware step
  always_comb begin
    cnt_nxt  = cnt_r;
    frs_nxt  = frs_r;
    pnd_nxt  = pnd_r;
    zlp_nxt  = zlp_r | (in_token && (vis == 3'h0));
    late_nxt = late_r & ~tx_ok;
    ovf      = 1'b0;
    disc     = 1'b0;
    if (sof) begin
      // Deferred decrements land, hidden sets show
      cnt_nxt = cnt_r - pnd_r - {2'b00, tx_ok};
      pnd_nxt = 3'h0;
      frs_nxt = 3'h0;
      zlp_nxt = 1'b0;
      // A late set still unsent goes once the next set exists
      if (late_nxt && (frs_r != 3'h0) && (cnt_nxt != 3'h0)) begin
        cnt_nxt = cnt_nxt - 3'h1;
        disc    = 1'b1;
      end
      late_nxt = zlp_r && (frs_r != 3'h0) && !disc;
    end else if (tx_ok) begin
      // Iso decrements wait for SOF, others act now
      if (iso) begin
        pnd_nxt = pnd_r + 3'h1;
      end else begin
        cnt_nxt = cnt_r - 3'h1;
      end
    end
    if (cnt_wr) begin
      if (cnt_nxt == SET_MAX) begin
        ovf = 1'b1;
      end else begin
        cnt_nxt = cnt_nxt + 3'h1;
        if (feat) begin
          frs_nxt = frs_nxt + 3'h1;
        end
        // Without the feature the set is offered at once
      end
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r  <= 3'h0;
      frs_r  <= 3'h0;
      pnd_r  <= 3'h0;
      zlp_r  <= 1'b0;
      late_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      frs_r  <= frs_nxt;
      pnd_r  <= pnd_nxt;
      zlp_r  <= zlp_nxt;
      late_r <= late_nxt;
    end
  end

  assign idx   = cnt_r[1:0];
  assign avail = vis != 3'h0;
endmodule

// File: hdl/utfs_top.sv
// Transmit FIFO status flags with Wishbone register access
//
// Contract
// - Two bit set count at bits 7:6
// - Feature on: new set hidden until SOF
// - Hidden: answer IN with zero length packet
// - Late write yields zero length that frame
// - Late set dropped after next frame
// - Bits 5:4 read zero, written zero
// - Empty flag while current set has no bytes
// - Empty flag never waits for SOF
// - Full flag when byte count equals size
// - Firmware increments count, USB decrements
// - Iso: USB changes land at SOF
// - Count write at 11 keeps 11, overrun
`timescale 1ns/10ps
module utfs_top
#(
  parameter logic [utfs_pkg::SZ_W-1:0] FSZ_DEF = utfs_pkg::FSZ_RST
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Firmware FIFO events
  input  wire logic        fw_byte_wr,
  input  wire logic        fw_cnt_wr,
  // USB side events
  input  wire logic        usb_sof,
  input  wire logic        usb_in_token,
  input  wire logic        usb_tx_done,
  // USB answers and status
  output logic             in_send_set,
  output logic             in_send_zlp,
  output logic             tx_late_set_discard,
  output logic             irq
);
  import utfs_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Declarations
  utfs_wb_e          st_r, st_nxt;      // Bus slave state
  logic              ack_r, ack_nxt;    // Bus acknowledge
  logic [31:0]       rd_r, rd_nxt;      // Read data
  logic [1:0]        ctl_r, ctl_nxt;    // Feature and iso bits
  logic [SZ_W-1:0]   fsz_r, fsz_nxt;    // Configured FIFO size
  logic [SZ_W-1:0]   byt_r, byt_nxt;    // Bytes in current set
  logic              emp_r, emp_nxt;    // Empty flag
  logic              ful_r, ful_nxt;    // Full flag
  logic              snd_r, snd_nxt;    // Send set pulse
  logic              zlp_r, zlp_nxt;    // Zero length pulse
  logic              dsc_r, dsc_nxt;    // Discard pulse
  logic [7:0]        flg;               // Flag register view
  logic              wr_go;             // Write commits now
  logic [1:0]        idx;               // Set count
  logic              avail;             // Set visible to host
  logic              ovf_ev;            // Overrun event
  logic              dsc_ev;            // Late discard event
  logic [IRQ_W-1:0]  ists;              // Interrupt status
  logic [IRQ_W-1:0]  imsk;              // Interrupt mask
  logic              irq_w;             // Interrupt from block
  logic              feat_w;            // Frame sync feature
  logic              iso_w;             // Iso mode

  assign feat_w = ctl_r[CTL_FEAT];
  assign iso_w  = ctl_r[CTL_ISO];

  ////////////////////////////////////////////////////////////////////
  // Set tracking and interrupts
  utfs_set_track u_trk (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .feat     (feat_w),
    .iso      (iso_w),
    .sof      (usb_sof),
    .cnt_wr   (fw_cnt_wr),
    .in_token (usb_in_token),
    .tx_done  (usb_tx_done),
    .idx      (idx),
    .avail    (avail),
    .ovf      (ovf_ev),
    .disc     (dsc_ev)
  );

  utfs_irq #(
    .W (IRQ_W)
  ) u_irq (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ev      ({usb_tx_done, dsc_ev, ovf_ev}),
    .clr_we  (wr_go && (wb_adr_i == OFS_ISTS)),
    .msk_we  (wr_go && (wb_adr_i == OFS_IMSK)),
    .wdat    (wb_dat_i[IRQ_W-1:0]),
    .status  (ists),
    .mask    (imsk),
    .irq     (irq_w)
  );

  ////////////////////////////////////////////////////////////////////
  // Flag register view; reserved bits and underrun read zero
  always_comb begin
    flg                        = 8'h00;
    flg[FLG_IDX_HI:FLG_IDX_LO] = idx;
    flg[FLG_EMPTY]             = emp_r;
    flg[FLG_FULL]              = ful_r;
    flg[FLG_OVF]               = ists[EV_OVF];
  end

  ////////////////////////////////////////////////////////////////////
  // Bus slave: request taken in idle, write commits on the ack edge
  assign wr_go = (st_r == WB_ACK) && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];

  always_comb begin
    st_nxt  = st_r;
    ack_nxt = 1'b0;
    rd_nxt  = rd_r;
    case (st_r)
      WB_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          st_nxt  = WB_ACK;
          ack_nxt = 1'b1;
          rd_nxt  = 32'h0000_0000;
          // Unmapped offsets read zero and ignore writes
          case (wb_adr_i)
            OFS_FLAG: rd_nxt[7:0] = flg;
            OFS_CTRL: rd_nxt[1:0] = ctl_r;
            OFS_ISTS: rd_nxt[IRQ_W-1:0] = ists;
            OFS_IMSK: rd_nxt[IRQ_W-1:0] = imsk;
            OFS_FSZ:  rd_nxt[SZ_W-1:0] = fsz_r;
            default:  rd_nxt = 32'h0000_0000;
          endcase
        end
      end
      WB_ACK: begin
        st_nxt = WB_IDLE;
      end
      default: begin
        st_nxt = WB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r  <= WB_IDLE;
      ack_r <= 1'b0;
      rd_r  <= 32'h0000_0000;
    end else begin
      st_r  <= st_nxt;
      ack_r <= ack_nxt;
      rd_r  <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control and size registers
  always_comb begin
    ctl_nxt = ctl_r;
    fsz_nxt = fsz_r;
    if (wr_go && (wb_adr_i == OFS_CTRL)) begin
      ctl_nxt = wb_dat_i[1:0];
    end
    // Size spans two lanes; the upper bits need lane one too
    if (wr_go && (wb_adr_i == OFS_FSZ) && wb_sel_i[1]) begin
      fsz_nxt = wb_dat_i[SZ_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl_r <= CTL_RST;
      fsz_r <= FSZ_DEF;
    end else begin
      ctl_r <= ctl_nxt;
      fsz_r <= fsz_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Byte count of the set being filled, with empty and full flags;
  // these follow firmware directly in every mode
  always_comb begin
    byt_nxt = byt_r;
    if (fw_cnt_wr) begin
      byt_nxt = '0;
    end else if (fw_byte_wr && (byt_r != fsz_r)) begin
      // Stuck at full: extra bytes are an overrun for a neighbour
      byt_nxt = byt_r + 1'b1;
    end
    emp_nxt = (byt_nxt == '0);
    ful_nxt = (byt_nxt == fsz_r);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      byt_r <= '0;
      emp_r <= 1'b1;
      ful_r <= 1'b0;
    end else begin
      byt_r <= byt_nxt;
      emp_r <= emp_nxt;
      ful_r <= ful_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // IN token answer one cycle later; nothing visible means zero length
  always_comb begin
    snd_nxt = usb_in_token && avail;
    zlp_nxt = usb_in_token && !avail;
    dsc_nxt = dsc_ev;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      snd_r <= 1'b0;
      zlp_r <= 1'b0;
      dsc_r <= 1'b0;
    end else begin
      snd_r <= snd_nxt;
      zlp_r <= zlp_nxt;
      dsc_r <= dsc_nxt;
    end
  end

  assign wb_dat_o            = rd_r;
  assign wb_ack_o            = ack_r;
  assign in_send_set         = snd_r;
  assign in_send_zlp         = zlp_r;
  assign tx_late_set_discard = dsc_r;
  assign irq                 = irq_w;

  ////////////////////////////////////////////////////////////////////
  // Assertions
  a_ovf_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (fw_cnt_wr && idx == 2'h3 && !usb_sof && !usb_tx_done)
      |=> (idx == 2'h3 && ists[EV_OVF]))
    else $error("count write at three lost the count or overrun");

  a_resv_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == WB_IDLE && wb_cyc_i && wb_stb_i && wb_adr_i == OFS_FLAG)
      |=> (wb_ack_o && wb_dat_o[5:4] == 2'b00 && wb_dat_o[7:6] == $past(idx)))
    else $error("flag read shows reserved bits or wrong count");

  a_empty_track: assert property (@(posedge clk) disable iff (sys_rst)
    (fw_cnt_wr && fsz_r != '0) |=> (emp_r && !ful_r) [*1] ##1 (emp_r || $past(fw_byte_wr)))
    else $error("empty flag wrong after set completion");

  a_fill_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (fw_byte_wr && !fw_cnt_wr && fsz_r != '0) |=> !emp_r)
    else $error("empty flag stayed after byte write");

  a_full_flag: assert property (@(posedge clk) disable iff (sys_rst)
    ful_r == (byt_r == $past(fsz_r)) || $past(wr_go))
    else $error("full flag disagrees with byte count");

  a_zlp_answer: assert property (@(posedge clk) disable iff (sys_rst)
    usb_in_token |=> (in_send_zlp != in_send_set) && (in_send_zlp == !$past(avail)))
    else $error("IN answer wrong");

  a_defer_vis: assert property (@(posedge clk) disable iff (sys_rst)
    (feat_w && !avail && !usb_sof && !wr_go) |=> !avail)
    else $error("set became visible before SOF");

  a_nofeat_now: assert property (@(posedge clk) disable iff (sys_rst)
    (!feat_w && fw_cnt_wr && idx != 2'h3 && !usb_tx_done && !usb_sof) |=> avail)
    else $error("set not offered at once without feature");

  a_iso_defer: assert property (@(posedge clk) disable iff (sys_rst)
    (iso_w && usb_tx_done && !usb_sof && !fw_cnt_wr) |=> (idx == $past(idx)))
    else $error("iso transmission changed count before SOF");

  // Outside iso mode and with no transmission done, a stored set must be offered right after a frame mark
  a_sof_reveal: assert property (@(posedge clk) disable iff (sys_rst)
    (usb_sof && !iso_w && !usb_tx_done && idx != 2'h0) |=> avail)
    else $error("stored set still hidden after SOF");

  // A dropped late set is reported on the pin and in status
  a_late_drop: assert property (@(posedge clk) disable iff (sys_rst)
    dsc_ev |=> (tx_late_set_discard && ists[EV_DISC]))
    else $error("late set drop not reported");

  // The byte that reaches the size raises full at once
  a_full_set: assert property (@(posedge clk) disable iff (sys_rst)
    (fw_byte_wr && !fw_cnt_wr && (byt_r + 11'h001) == fsz_r) |=> ful_r)
    else $error("full flag missing at configured size");
endmodule

// File: tb/utfs_usb_host_model.sv
// USB host side model: frame marks, IN tokens and acknowledges
`timescale 1ns/10ps
module utfs_usb_host_model (
  // Clock
  input  wire logic clk,
  // Answers from the device
  input  wire logic send_set,
  input  wire logic send_zlp,
  // Host events
  output logic      sof,
  output logic      in_token,
  output logic      tx_done
);
  // Idle at time zero so the device sees no stray event
  initial begin
    sof      = 1'b0;
    in_token = 1'b0;
    tx_done  = 1'b0;
  end
  // One start of frame pulse
  task automatic frame();
    @(posedge clk);
    sof <= 1'b1;
    @(posedge clk);
    sof <= 1'b0;
  endtask
  // IN token; only a real data packet is acknowledged, a zero length one is not
  task automatic in_req(output logic [1:0] ans);
    @(posedge clk);
    in_token <= 1'b1;
    @(posedge clk);
    in_token <= 1'b0;
    // Answer stands one cycle, so look mid-cycle
    @(negedge clk);
    ans = {send_set, send_zlp};
    if (ans === 2'b10) begin
      @(posedge clk);
      tx_done <= 1'b1;
      @(posedge clk);
      tx_done <= 1'b0;
    end
  endtask
endmodule

// File: tb/usb_tx_fifo_status_flags_tb.sv
// Self-checking bench for the transmit FIFO status flags
`timescale 1ns/10ps
module usb_tx_fifo_status_flags_tb;
  import utfs_pkg::*;
  // Bench driven inputs
  logic        clk, sys_rst, cyc, stb, we, byte_wr, cnt_wr;
  logic [4:0]  adr;
  logic [31:0] wdat;
  // Device outputs and host events
  logic [31:0] dat_o, rdat;
  logic        ack, sof, tok, done, snd_set, snd_zlp, disc, irq, hit;
  logic [1:0]  ans;
  int          err_total, compares, cycles;
  ////////////////////////////////////////////////////////////////
  utfs_top u_dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .fw_byte_wr(byte_wr), .fw_cnt_wr(cnt_wr), .usb_sof(sof),
    .usb_in_token(tok), .usb_tx_done(done), .in_send_set(snd_set),
    .in_send_zlp(snd_zlp), .tx_late_set_discard(disc), .irq(irq));
  utfs_usb_host_model u_host (.clk(clk), .send_set(snd_set), .send_zlp(snd_zlp),
    .sof(sof), .in_token(tok), .tx_done(done));
  // Free running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard: far above what the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Compare, count and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic single cycle; waits for ack however long it takes
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rdat = dat_o;
    cyc  <= 1'b0;
    stb  <= 1'b0;
    we   <= 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  // Firmware pulse: data byte or byte count
  task automatic fw(input bit cnt);
    @(posedge clk);
    if (cnt) cnt_wr <= 1'b1;
    else byte_wr <= 1'b1;
    @(posedge clk);
    cnt_wr  <= 1'b0;
    byte_wr <= 1'b0;
  endtask
  task automatic do_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  // Reset values and an unmapped offset
  task automatic t_reset();
    rd_chk(OFS_FLAG, 32'h08);
    rd_chk(OFS_CTRL, 32'h0);
    rd_chk(OFS_IMSK, 32'h0);
    rd_chk(OFS_FSZ, 32'h40);
    wb(1'b1, 5'h14, 32'hFF);
    rd_chk(5'h14, 32'h0);
  endtask
  // Feature off: set offered at once, count back to zero after ack
  task automatic t_no_feat();
    do_reset();
    // Single packet use: new set only while the count reads 00
    fw(1);
    rd_chk(OFS_FLAG, 32'h48);
    u_host.in_req(ans);
    chk({30'h0, ans}, 32'h2);
    rd_chk(OFS_FLAG, 32'h08);
    rd_chk(OFS_ISTS, 32'h4);
  endtask
  // Feature on: hidden until SOF, older set goes first
  task automatic t_feat();
    do_reset();
    wb(1'b1, OFS_CTRL, 32'h1);
    fw(1);
    u_host.in_req(ans);
    chk({30'h0, ans}, 32'h1);
    u_host.frame();
    fw(1);
    u_host.in_req(ans);
    chk({30'h0, ans}, 32'h2);
    u_host.in_req(ans);
    chk({30'h0, ans}, 32'h1);
    u_host.frame();
    u_host.in_req(ans);
    chk({30'h0, ans}, 32'h2);
    rd_chk(OFS_FLAG, 32'h08);
  endtask
  // One late write, then the right one: late set dropped
  task automatic t_late();
    do_reset();
    wb(1'b1, OFS_CTRL, 32'h1);
    u_host.frame();
    u_host.in_req(ans);
    chk({30'h0, ans}, 32'h1);
    // Late in this frame only, never in the next as well
    fw(1);
    u_host.frame();
    fw(1);
    u_host.frame();
    hit = 1'b0;
    repeat (3) begin
      @(negedge clk);
      hit = hit | disc;
    end
    chk({31'h0, hit}, 32'h1);
    rd_chk(OFS_ISTS, 32'h2);
    rd_chk(OFS_FLAG, 32'h48);
  endtask
  // Empty and full track bytes at once, even in iso mode
  task automatic t_flags();
    do_reset();
    wb(1'b1, OFS_CTRL, 32'h3);
    wb(1'b1, OFS_FSZ, 32'h2);
    fw(0);
    rd_chk(OFS_FLAG, 32'h00);
    fw(0);
    rd_chk(OFS_FLAG, 32'h04);
    fw(1);
    rd_chk(OFS_FLAG, 32'h48);
  endtask
  // Iso: decrement after a sent set waits for SOF
  task automatic t_iso();
    do_reset();
    wb(1'b1, OFS_CTRL, 32'h2);
    fw(1);
    u_host.in_req(ans);
    chk({30'h0, ans}, 32'h2);
    rd_chk(OFS_FLAG, 32'h48);
    u_host.frame();
    rd_chk(OFS_FLAG, 32'h08);
  endtask
  // Count saturates at 3, overrun raises, masks and clears the interrupt
  task automatic t_ovf();
    do_reset();
    repeat (3) fw(1);
    rd_chk(OFS_FLAG, 32'hC8);
    fw(1);
    rd_chk(OFS_FLAG, 32'hC9);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, OFS_IMSK, 32'h1);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, OFS_ISTS, 32'h1);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    rd_chk(OFS_FLAG, 32'hC8);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {sys_rst, cyc, stb, we, byte_wr, cnt_wr} = 6'h20;
    adr       = 5'h00;
    wdat      = 32'h0;
    err_total = 0;
    compares  = 0;
    cycles    = 0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_no_feat();
    t_feat();
    t_late();
    t_flags();
    t_iso();
    t_ovf();
    give_verdict();
  end
endmodule
